// ### hw/tdp_pkg.sv
// constants and state layout for the t1/e1 transmit digital path
package tdp_pkg;
    // ********************************
    // timing
    // ********************************
    localparam int MCLK_KHZ = 40000;
    localparam int T1_RATE_KBPS = 1544;
    localparam int E1_RATE_KBPS = 2048;
    localparam int LOSS_PERIODS = 2;
    localparam logic [5:0] LOSS_T1_CYC =
        6'((LOSS_PERIODS * MCLK_KHZ + T1_RATE_KBPS - 1) / T1_RATE_KBPS);
    localparam logic [5:0] LOSS_E1_CYC =
        6'((LOSS_PERIODS * MCLK_KHZ + E1_RATE_KBPS - 1) / E1_RATE_KBPS);
    // last zero of a run that triggers substitution
    localparam logic [2:0] T1_RUN_LAST = 3'h7;
    localparam logic [2:0] E1_RUN_LAST = 3'h3;
    // ********************************
    // register indices, byte address = 4 * index
    // ********************************
    localparam logic [7:0] IDX_GLOBAL = 8'h01;
    localparam logic [7:0] IDX_SMOOTH = 8'h10;
    localparam logic [7:0] IDX_RXLINE = 8'h11;
    localparam logic [7:0] IDX_LINEUNIT = 8'h13;
    localparam logic [7:0] IDX_STATUS = 8'h14;
    // ********************************
    // field positions
    // ********************************
    localparam int B_TXDIR = 0;
    localparam int B_E1 = 1;
    localparam int B_SM_EN = 0;
    localparam int B_SM_DIR = 1;
    localparam int B_SINGLE = 0;
    localparam int B_ZS = 1;
    localparam int B_MAN = 0;
    localparam int B_AUTO = 1;
    localparam int B_ALTSEL = 2;
    localparam int B_PINEN = 3;
    localparam int B_RLL = 4;
    localparam int B_LDL = 5;
    localparam int B_ST_LOST = 0;
    localparam int B_ST_ALARM = 1;
    localparam int B_ST_ALT = 2;
    // ********************************
    // synchroniser lanes
    // ********************************
    localparam int SY_TXCLK = 0;
    localparam int SY_CLOCK_RATE_ADAPTER = 1;
    localparam int SY_ALT1 = 2;
    localparam int SY_ALTE = 3;
    localparam int SY_RXCLK = 4;
    localparam int SY_SMCLK = 5;
    localparam int SY_POS = 6;
    localparam int SY_NEG = 7;
    localparam int SY_RXP = 8;
    localparam int SY_RXN = 9;
    localparam int SY_SMP = 10;
    localparam int SY_SMN = 11;
    localparam int SY_HOST = 12;
    localparam int SY_SINGLE = 13;
    localparam int SY_ZS = 14;
    localparam int SY_SMSEL = 15;
    localparam int SY_SMDIR = 18;
    localparam int SY_ALARM_N = 19;
    localparam int SY_E1 = 20;
    localparam int SYNC_W = 21;
    // ********************************
    // state
    // ********************************
    typedef struct packed {
        logic [SYNC_W-1:0] sy1;
        logic [SYNC_W-1:0] sy2;
        logic [5:0] clk_prev;
        logic glob_dir;
        logic glob_e1;
        logic sm_en;
        logic sm_dir;
        logic single_r;
        logic zs_r;
        logic man_r;
        logic auto_r;
        logic altsel_r;
        logic pinen_r;
        logic rll_r;
        logic ldl_r;
        logic [7:0][1:0] win;
        logic [2:0] zcnt;
        logic last_pos;
        logic par;
        logic [5:0] mon_cnt;
        logic lost;
        logic ais_pos;
        logic tip;
        logic ring;
        logic line_stb;
        logic enc_pos;
        logic enc_neg;
        logic enc_stb;
        logic [31:0] prdata;
        logic slverr;
    } tdp_state_type;
    localparam tdp_state_type STATE_RST = '0;
endpackage

// ### hw/tdp_tx_path.sv
// transmit digital path of one line channel with apb registers
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module tdp_tx_path #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // framer side
    input wire logic tx_line_clock_i,
    output logic tx_line_clock_o,
    output logic tx_line_clock_oe_o,
    input wire logic tx_positive_rail_in_i,
    input wire logic tx_negative_rail_in_i,
    input wire logic rate_adapter_clock_i,
    // alarm
    input wire logic alt_clock_t1_in_i,
    input wire logic alt_clock_e1_in_i,
    input wire logic manual_alarm_request_n_i,
    // hardware mode pins
    input wire logic host_mode_i,
    input wire logic hw_single_rail_i,
    input wire logic hw_zero_suppress_i,
    input wire logic [2:0] smoother_select_pins_i,
    input wire logic hw_smoother_direction_i,
    input wire logic hw_e1_mode_i,
    // receiver for remote loopback
    input wire logic rx_clock_i,
    input wire logic rx_pos_i,
    input wire logic rx_neg_i,
    // jitter smoother
    input wire logic smoothed_clock_i,
    input wire logic smoothed_pos_i,
    input wire logic smoothed_neg_i,
    output logic enc_pos_o,
    output logic enc_neg_o,
    output logic enc_strobe_o,
    // toward the pulse shaper
    output logic line_out_tip_o,
    output logic line_out_ring_o,
    output logic line_strobe_o,
    // status
    output logic smoother_tx_path_o,
    output logic smoother_rx_path_o,
    output logic zero_suppress_active_o,
    output logic local_digital_loopback_o,
    output logic tx_clock_lost_o,
    output logic alarm_active_o
);
    import tdp_pkg::*;

    if (ADDR_W < 10) begin : g_chk
        $error("ADDR_W must be at least 10");
    end

    tdp_state_type r;
    tdp_state_type n;
    logic [SYNC_W-1:0] sync_in;
    logic [5:0] falls;
    logic host, single, dual, zs_act, sm_en, sm_dir, sm_tx, sm_rx, e1;
    logic drive_clk, pin_alarm, remote_line_loopback, manual, alarm, use_alt;
    logic tx_lvl, tx_fall, tx_any, alt_fall, a_edge, b_edge;
    logic d_pos, d_neg;
    logic [1:0] b_data;
    logic [5:0] loss_lim;
    logic [2:0] run_last;
    logic [7:0] idx;
    logic hit;

    // ********************************
    // input synchronisers
    // ********************************
    assign sync_in = {hw_e1_mode_i, manual_alarm_request_n_i,
        hw_smoother_direction_i, smoother_select_pins_i, hw_zero_suppress_i,
        hw_single_rail_i, host_mode_i, smoothed_neg_i, smoothed_pos_i,
        rx_neg_i, rx_pos_i, tx_negative_rail_in_i, tx_positive_rail_in_i,
        smoothed_clock_i, rx_clock_i, alt_clock_e1_in_i, alt_clock_t1_in_i,
        rate_adapter_clock_i, tx_line_clock_i};
    assign falls = r.clk_prev & ~r.sy2[5:0];

    // ********************************
    // mode decode
    // ********************************
    assign host = r.sy2[SY_HOST];
    assign single = host ? r.single_r : r.sy2[SY_SINGLE];
    assign remote_line_loopback = host & r.rll_r;
    assign dual = ~single | remote_line_loopback;
    assign zs_act = single & (host ? r.zs_r : r.sy2[SY_ZS]);
    assign sm_en = host ? r.sm_en : |r.sy2[SY_SMSEL+:3];
    assign sm_dir = host ? r.sm_dir : r.sy2[SY_SMDIR];
    assign sm_tx = sm_en & ~sm_dir;
    assign sm_rx = sm_en & sm_dir;
    assign e1 = host ? r.glob_e1 : r.sy2[SY_E1];
    assign drive_clk = host & r.glob_dir;
    assign pin_alarm = ~r.sy2[SY_ALARM_N];
    assign manual = (host & ~r.pinen_r) ? r.man_r : pin_alarm;
    assign alarm = manual | (host & r.auto_r & r.lost);
    assign use_alt = host ? r.altsel_r : r.lost;
    assign loss_lim = e1 ? LOSS_E1_CYC : LOSS_T1_CYC;
    assign run_last = e1 ? E1_RUN_LAST : T1_RUN_LAST;

    // ********************************
    // clock edges
    // ********************************
    assign tx_lvl = drive_clk ? r.sy2[SY_CLOCK_RATE_ADAPTER] : r.sy2[SY_TXCLK];
    assign tx_fall = drive_clk ? falls[SY_CLOCK_RATE_ADAPTER] : falls[SY_TXCLK];
    assign tx_any = drive_clk ? (r.clk_prev[SY_CLOCK_RATE_ADAPTER] ^ tx_lvl)
                              : (r.clk_prev[SY_TXCLK] ^ tx_lvl);
    assign alt_fall = e1 ? falls[SY_ALTE] : falls[SY_ALT1];
    assign a_edge = remote_line_loopback ? (sm_rx ? falls[SY_SMCLK] : falls[SY_RXCLK]) : tx_fall;
    always_comb begin
        if (remote_line_loopback) begin
            b_edge = sm_tx ? falls[SY_SMCLK] : a_edge;
        end else if (alarm && use_alt) begin
            b_edge = alt_fall;
        end else begin
            b_edge = sm_tx ? falls[SY_SMCLK] : tx_fall;
        end
    end
    assign d_pos = remote_line_loopback ? r.sy2[SY_RXP] : r.sy2[SY_POS];
    assign d_neg = remote_line_loopback ? r.sy2[SY_RXN] : r.sy2[SY_NEG];
    assign b_data = sm_tx ? {r.sy2[SY_SMP], r.sy2[SY_SMN]} : r.win[7];

    // ********************************
    // apb decode
    // ********************************
    assign idx = paddr_i[9:2];
    always_comb begin
        hit = (paddr_i[ADDR_W-1:10] == '0);
        case (idx)
            IDX_GLOBAL, IDX_SMOOTH, IDX_RXLINE, IDX_LINEUNIT, IDX_STATUS: begin
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // ********************************
    // next state
    // ********************************
    always_comb begin
        logic vp;
        vp = 1'b0;
        n = r;
        n.sy1 = sync_in;
        n.sy2 = r.sy1;
        n.clk_prev = r.sy2[5:0];
        n.line_stb = 1'b0;
        n.enc_stb = 1'b0;
        // register access
        if (psel_i && !penable_i) begin
            n.prdata = '0;
            n.slverr = ~hit;
            case (idx)
                IDX_GLOBAL: begin
                    n.prdata[B_TXDIR] = r.glob_dir;
                    n.prdata[B_E1] = r.glob_e1;
                end
                IDX_SMOOTH: begin
                    n.prdata[B_SM_EN] = r.sm_en;
                    n.prdata[B_SM_DIR] = r.sm_dir;
                end
                IDX_RXLINE: begin
                    n.prdata[B_SINGLE] = r.single_r;
                    n.prdata[B_ZS] = r.zs_r;
                end
                IDX_LINEUNIT: begin
                    n.prdata[B_MAN] = r.man_r;
                    n.prdata[B_AUTO] = r.auto_r;
                    n.prdata[B_ALTSEL] = r.altsel_r;
                    n.prdata[B_PINEN] = r.pinen_r;
                    n.prdata[B_RLL] = r.rll_r;
                    n.prdata[B_LDL] = r.ldl_r;
                end
                IDX_STATUS: begin
                    n.prdata[B_ST_LOST] = r.lost;
                    n.prdata[B_ST_ALARM] = alarm;
                    n.prdata[B_ST_ALT] = use_alt;
                end
                default: begin
                end
            endcase
        end
        if (psel_i && penable_i && pwrite_i && hit) begin
            case (idx)
                IDX_GLOBAL: begin
                    n.glob_dir = pwdata_i[B_TXDIR];
                    n.glob_e1 = pwdata_i[B_E1];
                end
                IDX_SMOOTH: begin
                    n.sm_en = pwdata_i[B_SM_EN];
                    n.sm_dir = pwdata_i[B_SM_DIR];
                end
                IDX_RXLINE: begin
                    n.single_r = pwdata_i[B_SINGLE];
                    n.zs_r = pwdata_i[B_ZS];
                end
                IDX_LINEUNIT: begin
                    n.man_r = pwdata_i[B_MAN];
                    n.auto_r = pwdata_i[B_AUTO];
                    n.altsel_r = pwdata_i[B_ALTSEL];
                    n.pinen_r = pwdata_i[B_PINEN];
                    n.rll_r = pwdata_i[B_RLL];
                    n.ldl_r = pwdata_i[B_LDL];
                end
                default: begin
                end
            endcase
        end
        // transmit clock monitor
        if (tx_any) begin
            n.mon_cnt = '0;
            n.lost = 1'b0;
        end else if (r.mon_cnt >= loss_lim) begin
            n.lost = 1'b1;
        end else begin
            n.mon_cnt = r.mon_cnt + 6'h01;
        end
        // capture and line coding, eight-bit look-ahead window
        if (a_edge) begin
            n.win = {r.win[6:0], 2'b00};
            n.enc_stb = 1'b1;
            n.enc_pos = r.win[7][1];
            n.enc_neg = r.win[7][0];
            if (dual) begin
                n.win[0] = {d_pos, d_neg};
                n.zcnt = '0;
            end else if (d_pos) begin
                n.win[0] = {~r.last_pos, r.last_pos};
                n.last_pos = ~r.last_pos;
                n.par = ~r.par;
                n.zcnt = '0;
            end else if (zs_act && r.zcnt == run_last) begin
                n.zcnt = '0;
                if (!e1) begin
                    n.win[0] = {r.last_pos, ~r.last_pos};
                    n.win[1] = {~r.last_pos, r.last_pos};
                    n.win[3] = {~r.last_pos, r.last_pos};
                    n.win[4] = {r.last_pos, ~r.last_pos};
                end else begin
                    vp = r.par ? r.last_pos : ~r.last_pos;
                    n.win[0] = {vp, ~vp};
                    n.win[3] = r.par ? 2'b00 : {vp, ~vp};
                    n.last_pos = vp;
                    n.par = 1'b0;
                end
            end else begin
                n.zcnt = r.zcnt + 3'h1;
            end
        end
        // alarm generator and line output
        if (b_edge) begin
            n.line_stb = 1'b1;
            if (alarm) begin
                n.ais_pos = ~r.ais_pos;
                n.tip = ~r.ais_pos;
                n.ring = r.ais_pos;
            end else begin
                n.tip = b_data[1];
                n.ring = b_data[0];
            end
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r <= STATE_RST;
        end else begin
            r <= n;
        end
    end

    // ********************************
    // outputs
    // ********************************
    assign prdata_o = r.prdata;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & r.slverr;
    assign tx_line_clock_o = r.sy2[SY_CLOCK_RATE_ADAPTER];
    assign tx_line_clock_oe_o = drive_clk;
    assign enc_pos_o = r.enc_pos;
    assign enc_neg_o = r.enc_neg;
    assign enc_strobe_o = r.enc_stb;
    assign line_out_tip_o = r.tip;
    assign line_out_ring_o = r.ring;
    assign line_strobe_o = r.line_stb;
    assign smoother_tx_path_o = sm_tx;
    assign smoother_rx_path_o = sm_rx;
    assign zero_suppress_active_o = zs_act;
    assign local_digital_loopback_o = host & r.ldl_r;
    assign tx_clock_lost_o = r.lost;
    assign alarm_active_o = alarm;

    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    AST_DUAL_CAPTURE: assert property (a_edge && dual |=>
        r.win[0] == $past({d_pos, d_neg})) else $error("dual rail not captured");
    AST_CLK_DIR: assert property (tx_line_clock_oe_o |-> host)
        else $error("clock pin driven outside host mode");
    AST_AMI_ALT: assert property (a_edge && !dual && d_pos |=>
        r.win[0] == {~$past(r.last_pos), $past(r.last_pos)})
        else $error("mark polarity not alternating");
    AST_B8ZS: assert property (a_edge && !dual && !d_pos && zs_act && !e1
        && r.zcnt == T1_RUN_LAST |=> r.win[0] == r.win[4]
        && r.win[1] == r.win[3] && r.win[0] != r.win[1] && r.win[2] == 2'b00)
        else $error("bad eight-zero substitution");
    AST_HDB3: assert property (a_edge && !dual && !d_pos && zs_act && e1
        && r.zcnt == E1_RUN_LAST && r.par |=> r.win[0][1] == $past(r.last_pos)
        && r.win[3] == 2'b00) else $error("bad four-zero substitution");
    AST_ZS_SINGLE: assert property (zero_suppress_active_o |-> single)
        else $error("zero suppression in dual rail");
    AST_ONE_PATH: assert property (!(smoother_tx_path_o && smoother_rx_path_o))
        else $error("smoother in both paths");
    AST_ALARM_ONES: assert property (b_edge && alarm |=>
        line_strobe_o && (line_out_tip_o ^ line_out_ring_o))
        else $error("alarm output not a mark");
    AST_LDL_DATA: assert property (a_edge |=> enc_strobe_o
        && enc_pos_o == $past(r.win[7][1])) else $error("loopback data altered");
    AST_LOSS: assert property (!tx_any [*8] ##1 tx_any |=> !r.lost)
        else $error("clock loss not cleared");
    AST_AUTO: assert property (host && r.auto_r && r.lost |-> alarm_active_o)
        else $error("automatic alarm missing");
    AST_LOSS_SET: assert property (!tx_any && r.mon_cnt >= loss_lim |=> r.lost)
        else $error("clock loss not flagged");
    AST_SINGLE_SPACE: assert property (a_edge && !dual && !d_pos && !zs_act |=>
        r.win[0] == 2'b00) else $error("space not sent for zero data");
    AST_ALT_CLOCK: assert property (alarm && use_alt && !remote_line_loopback |-> b_edge == alt_fall)
        else $error("alarm not on alternate clock");
    AST_PIN_ENABLE: assert property (host && r.pinen_r && !r.auto_r |->
        alarm_active_o == !r.sy2[SY_ALARM_N]) else $error("alarm pin not obeyed");
endmodule
`default_nettype wire

// ### tb/tdp_framer_model.sv
// behavioural framer driving transmit clock and rails
`timescale 1ns/1ps
`default_nettype none
module tdp_framer_model (
    // clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // frame request
    input wire logic start_i,
    input wire logic [6:0] nbits_i,
    input wire logic [63:0] pos_i,
    input wire logic [63:0] neg_i,
    // toward the device
    output logic clk_o,
    output logic pos_o,
    output logic neg_o,
    output logic busy_o
);
    logic [2:0] ph;
    logic [6:0] k;
    // ********************************
    // one bit every 8 mclk, 200 ns
    // ********************************
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            {clk_o, pos_o, neg_o, busy_o, ph, k} <= '0;
        end else if (!busy_o) begin
            ph <= '0;
            k <= '0;
            busy_o <= start_i;
        end else begin
            ph <= ph + 3'h1;
            if (ph == 3'h0) begin
                // rails change on the rise, stable over the fall
                clk_o <= 1'b1;
                pos_o <= pos_i[k[5:0]];
                neg_o <= neg_i[k[5:0]];
            end
            if (ph == 3'h4) begin
                clk_o <= 1'b0;
            end
            if (ph == 3'h7) begin
                k <= k + 7'h1;
                if (k == nbits_i - 7'h1) begin
                    // clock stands still, released rails invert
                    busy_o <= 1'b0;
                    pos_o <= ~pos_o;
                    neg_o <= ~neg_o;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/t1e1_transmit_digital_path_tb.sv
// self-checking bench for the transmit digital path
`timescale 1ns/1ps
`default_nettype none
module t1e1_transmit_digital_path_tb;
    import tdp_pkg::*;
    logic mclk_i, arst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic tx_line_clock_i, tx_line_clock_o, tx_line_clock_oe_o;
    logic tx_positive_rail_in_i, tx_negative_rail_in_i, manual_alarm_request_n_i;
    logic host_mode_i, hw_single_rail_i, hw_zero_suppress_i, hw_smoother_direction_i;
    logic hw_e1_mode_i, enc_pos_o, enc_neg_o, enc_strobe_o, line_out_tip_o;
    logic [2:0] smoother_select_pins_i;
    logic line_out_ring_o, line_strobe_o, smoother_tx_path_o, smoother_rx_path_o;
    logic zero_suppress_active_o, local_digital_loopback_o, tx_clock_lost_o, alarm_active_o;
    logic fr_start, fr_busy;
    logic [6:0] fr_n;
    logic [63:0] fr_p, fr_q;
    logic [3:0] aux = 4'h0;
    logic [1:0] seen;
    logic [1:0] q[$];
    int n_errors, n_compared, enc_marks, cycles;

    tdp_tx_path i_dut (.mclk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .tx_line_clock_i, .tx_line_clock_o,
        .tx_line_clock_oe_o, .tx_positive_rail_in_i, .tx_negative_rail_in_i,
        .rate_adapter_clock_i(aux[2]), .alt_clock_t1_in_i(aux[2]), .alt_clock_e1_in_i(aux[2]),
        .manual_alarm_request_n_i, .host_mode_i, .hw_single_rail_i, .hw_zero_suppress_i,
        .smoother_select_pins_i, .hw_smoother_direction_i, .hw_e1_mode_i,
        .rx_clock_i(aux[2]), .rx_pos_i(aux[3]), .rx_neg_i(~aux[3]), .smoothed_clock_i(aux[2]),
        .smoothed_pos_i(aux[3]), .smoothed_neg_i(~aux[3]), .enc_pos_o, .enc_neg_o,
        .enc_strobe_o, .line_out_tip_o, .line_out_ring_o, .line_strobe_o, .smoother_tx_path_o,
        .smoother_rx_path_o, .zero_suppress_active_o, .local_digital_loopback_o,
        .tx_clock_lost_o, .alarm_active_o);
    tdp_framer_model i_framer (.mclk_i, .arst_n_i, .start_i(fr_start), .nbits_i(fr_n),
        .pos_i(fr_p), .neg_i(fr_q), .clk_o(tx_line_clock_i), .pos_o(tx_positive_rail_in_i),
        .neg_o(tx_negative_rail_in_i), .busy_o(fr_busy));

    // ********************************
    // clock, monitors, timeout
    // ********************************
    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        aux <= aux + 4'h1;
        if (line_strobe_o === 1'b1) q.push_back({line_out_tip_o, line_out_ring_o});
        if (enc_strobe_o === 1'b1 && (enc_pos_o | enc_neg_o) === 1'b1) enc_marks++;
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            conclude();
        end
    end

    // ********************************
    // tasks
    // ********************************
    task automatic conclude();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        logic rdy;
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= {2'b00, idx, 2'b00};
        pwdata_i <= wd;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge mclk_i);
            rd = prdata_o;
            er = pslverr_o;
            rdy = pready_o;
        end while (rdy !== 1'b1);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
        repeat (5) @(posedge mclk_i);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic eexp);
        logic [31:0] r;
        logic e;
        apb(1'b0, idx, 32'h0, r, e);
        cmp("prdata", exp, r);
        cmp("pslverr", {31'h0, eexp}, {31'h0, e});
    endtask
    // kinds: 0 space, 1 alternating mark, 2 violation, 3 either space or mark
    task automatic send(input logic [47:0] d, input logic [47:0] nd, input int mode,
                        input logic [47:0] e);
        int kd[48];
        int zr;
        int cnt;
        int known;
        logic prev;
        logic [1:0] ex;
        q.delete();
        fr_p <= {8'hff, d, 8'hff};
        fr_q <= {8'h00, nd, 8'h00};
        fr_n <= 7'd64;
        fr_start <= 1'b1;
        @(posedge mclk_i);
        fr_start <= 1'b0;
        repeat (2) @(posedge mclk_i);
        while (fr_busy !== 1'b0) @(posedge mclk_i);
        repeat (10) @(posedge mclk_i);
        zr = 0;
        cnt = 0;
        known = 0;
        for (int i = 0; i < 48; i++) begin
            kd[i] = e[i] ? 1 : 0;
            cnt = cnt + kd[i];
            zr = e[i] ? 0 : zr + 1;
            if (mode == 2 && zr == 8) begin
                kd[i-4] = 2;
                kd[i-3] = 1;
                kd[i-1] = 2;
                kd[i] = 1;
                zr = 0;
            end
            if (mode == 3 && zr == 4) begin
                kd[i-3] = !known ? 3 : (cnt % 2 == 0) ? 1 : 0;
                kd[i] = 2;
                cnt = 0;
                known = 1;
                zr = 0;
            end
        end
        cmp("strobes", 32'd64, q.size());
        prev = q[15][1];
        for (int i = 0; i < 48; i++) begin
            if (mode == 0) ex = {d[i], nd[i]};
            else if (kd[i] == 0 || (kd[i] == 3 && q[16+i] == 2'b00)) ex = 2'b00;
            else if (kd[i] == 2) ex = {prev, ~prev};
            else ex = {~prev, prev};
            if (ex != 2'b00) prev = ex[1];
            cmp("line", {30'h0, ex}, {30'h0, q[16+i]});
        end
        q.delete();
    endtask
    task automatic alt_run();
        q.delete();
        repeat (80) @(posedge mclk_i);
        cmp("alt_strobes", 1, q.size() >= 8);
        for (int i = 1; i < q.size(); i++) cmp("alarm_mark", {30'h0, ~q[i-1]}, {30'h0, q[i]});
    endtask

    // ********************************
    // main sequence
    // ********************************
    initial begin
        {arst_n_i, psel_i, penable_i, pwrite_i, fr_start, hw_single_rail_i} = '0;
        {hw_zero_suppress_i, hw_smoother_direction_i, hw_e1_mode_i} = '0;
        {paddr_i, pwdata_i, smoother_select_pins_i, fr_n, fr_p, fr_q} = '0;
        {n_errors, n_compared, enc_marks} = '0;
        manual_alarm_request_n_i = 1'b1;
        host_mode_i = 1'b1;
        repeat (6) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        repeat (5) @(posedge mclk_i);
        rd(IDX_LINEUNIT, 32'h0, 1'b0);
        rd(8'h02, 32'h0, 1'b1);
        wr(IDX_RXLINE, 32'h2);
        cmp("zs_active", 0, zero_suppress_active_o);
        send(48'h00ff_0000_a5c3, 48'h0f00_ff00_0a0c, 0, '0);
        wr(IDX_RXLINE, 32'h1);
        send(48'h9000_3c81_00f1, 48'h6fff_c37e_ff0e, 1, 48'h9000_3c81_00f1);
        wr(IDX_RXLINE, 32'h3);
        cmp("zs_active", 1, zero_suppress_active_o);
        send(48'h8000_0100_2001, '1, 2, 48'h8000_0100_2001);
        wr(IDX_GLOBAL, 32'h2);
        send(48'h8104_2100_9001, '1, 3, 48'h8104_2100_9001);
        wr(IDX_LINEUNIT, 32'h6);
        cmp("lost", 0, tx_clock_lost_o);
        repeat (60) @(posedge mclk_i);
        cmp("lost", 1, tx_clock_lost_o);
        cmp("alarm", 1, alarm_active_o);
        alt_run();
        rd(IDX_STATUS, 32'h7, 1'b0);
        wr(IDX_RXLINE, 32'h1);
        wr(IDX_LINEUNIT, 32'h29);
        cmp("alarm", 0, alarm_active_o);
        cmp("ldl", 1, local_digital_loopback_o);
        manual_alarm_request_n_i <= 1'b0;
        repeat (5) @(posedge mclk_i);
        cmp("alarm", 1, alarm_active_o);
        enc_marks = 0;
        send('0, '0, 1, '1);
        cmp("enc_marks", 16, enc_marks);
        wr(IDX_LINEUNIT, 32'h11);
        alt_run();
        wr(IDX_LINEUNIT, 32'h10);
        alt_run();
        wr(IDX_LINEUNIT, 32'h0);
        wr(IDX_SMOOTH, 32'h1);
        cmp("sm_tx", 1, smoother_tx_path_o);
        cmp("sm_rx", 0, smoother_rx_path_o);
        wr(IDX_SMOOTH, 32'h0);
        wr(IDX_GLOBAL, 32'h1);
        cmp("clk_oe", 1, tx_line_clock_oe_o);
        seen = 2'b00;
        repeat (16) begin
            @(posedge mclk_i);
            seen[tx_line_clock_o] = 1'b1;
        end
        cmp("clk_out", 32'h3, {30'h0, seen});
        host_mode_i <= 1'b0;
        {hw_single_rail_i, hw_zero_suppress_i, hw_smoother_direction_i} <= 3'h7;
        smoother_select_pins_i <= 3'h1;
        hw_e1_mode_i <= 1'b1;
        repeat (80) @(posedge mclk_i);
        cmp("clk_oe", 0, tx_line_clock_oe_o);
        cmp("zs_active", 1, zero_suppress_active_o);
        cmp("sm_rx", 1, smoother_rx_path_o);
        cmp("sm_tx", 0, smoother_tx_path_o);
        cmp("alarm", 1, alarm_active_o);
        alt_run();
        conclude();
    end
endmodule
`default_nettype wire
